//--- stso_map.vh
// Constants for the serial stream output framer with redundancy bytes.
// Operation
// (R1) Polarity of clock and strobes is configurable.
// (R2) Outputs change on falling bit clock edge.
// (R3) First-byte marker spans exactly eight bit clocks.
// (R4) Valid window covers 188 payload bytes only.
// (R5) Error flag spans the whole errored packet.
// (R6) One bit per clock on one line.
// (R7) Each payload is 188 bytes long.
// (R8) Bytes go out most significant bit first.
`ifndef STSO_MAP_VH
`define STSO_MAP_VH

// ----------------------------------------------------------------------
// Packet layout
// ----------------------------------------------------------------------
`define STSO_PAYLOAD_BYTES 188
`define STSO_REDUND_BYTES 20
`define STSO_BITS_PER_BYTE 8
`define STSO_BYTE_W 8
`define STSO_POS_W 8

// ----------------------------------------------------------------------
// Fifo shape and reset values
// ----------------------------------------------------------------------
`define STSO_FIFO_DEPTH 4
`define STSO_FIFO_W 10
`define STSO_RST_LOW 1'b0
`define STSO_RST_BYTE 8'h00

`endif

//--- stso_fifo.v
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module stso_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 4
) (
  input wire clk_in,              // Core clock.
  input wire rst_b_in,            // Asynchronous reset, active low.
  input wire [WIDTH-1:0] wr_data_in, // Word to store.
  input wire wr_valid_in,         // Writer offers a word.
  output wire wr_ready_out,       // Room for a word, from a flop.
  output wire [WIDTH-1:0] rd_data_out, // Oldest stored word.
  output wire rd_valid_out,       // A word is waiting, from a flop.
  input wire rd_ready_in          // Reader takes the word.
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function integer stso_clog2;
    input integer val;
    integer n;
    begin
      n = 0;
      while ((1 << n) < val)
        n = n + 1;
      stso_clog2 = (n < 1) ? 1 : n;
    end
  endfunction

  localparam AW = stso_clog2(DEPTH);
  localparam CW = stso_clog2(DEPTH + 1);
  localparam integer FULL_I = DEPTH;
  localparam integer LAST_I = DEPTH - 1;
  // Counts are cut to the pointer and counter widths on purpose.
  localparam [CW-1:0] FULL_CNT = FULL_I[CW-1:0];
  localparam [AW-1:0] LAST_IDX = LAST_I[AW-1:0];

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [CW-1:0] count_q;
  reg [CW-1:0] count_d;
  reg ready_q;
  reg valid_q;
  wire do_wr;
  wire do_rd;

  // Flags are kept in flops so the ready seen outside has no logic path.
  assign do_wr = wr_valid_in & ready_q;
  assign do_rd = rd_ready_in & valid_q;
  assign wr_ready_out = ready_q;
  assign rd_valid_out = valid_q;
  assign rd_data_out = mem_q[rd_ptr_q];

  // Next occupancy from the two handshakes.
  always @*
  begin
    count_d = count_q;
    if (do_wr & ~do_rd)
      count_d = count_q + {{(CW-1){1'b0}}, 1'b1};
    else if (do_rd & ~do_wr)
      count_d = count_q - {{(CW-1){1'b0}}, 1'b1};
  end

  // Storage is written without reset; only pointers, count and flags need one.
  always @(posedge clk_in)
  begin
    if (do_wr)
      mem_q[wr_ptr_q] <= wr_data_in;
  end

  // Pointers, count and registered flags.
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {CW{1'b0}};
      ready_q <= 1'b1;
      valid_q <= 1'b0;
    end
    else
    begin
      if (do_wr)
        wr_ptr_q <= (wr_ptr_q == LAST_IDX) ? {AW{1'b0}} :
                    wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      if (do_rd)
        rd_ptr_q <= (rd_ptr_q == LAST_IDX) ? {AW{1'b0}} :
                    rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      count_q <= count_d;
      ready_q <= (count_d != FULL_CNT);
      valid_q <= (count_d != {CW{1'b0}});
    end
  end

endmodule // stso_fifo

`default_nettype wire

//--- stso_framer.v
// Serial stream framer: bytes in, one bit per output bit clock out.
`timescale 1ns/1ps
`default_nettype none
`include "stso_map.vh"

module stso_framer #(
  parameter PAYLOAD_BYTES = `STSO_PAYLOAD_BYTES,
  parameter REDUND_BYTES = `STSO_REDUND_BYTES,
  parameter FIFO_DEPTH = `STSO_FIFO_DEPTH
) (
  input wire clk_in,              // Core clock, 250 MHz.
  input wire rst_b_in,            // Asynchronous reset, active low.
  input wire bit_rate_clk_in,     // Bit rate reference, foreign domain.
  input wire [7:0] byte_data_in,  // Packet byte from the decoder.
  input wire byte_first_in,       // Byte is the first of a packet.
  input wire byte_error_in,       // Packet is uncorrectable (first byte).
  input wire byte_valid_in,       // Byte offered.
  output wire byte_ready_out,     // Byte accepted when valid is high.
  input wire inv_clock_in,        // Invert the output bit clock.
  input wire inv_first_in,        // First-byte marker active low.
  input wire inv_valid_in,        // Valid window active low.
  input wire inv_error_in,        // Error flag active low.
  output reg out_bit_clock_out,   // Output bit clock.
  output reg serial_stream_out,   // Serial data line.
  output reg first_byte_mark_out, // First-byte marker.
  output reg packet_valid_window_out, // Payload window.
  output reg packet_error_flag_out    // Whole-packet error flag.
);

  // --------------------------------------------------------------------
  // Constants and states
  // --------------------------------------------------------------------
  localparam PW = `STSO_POS_W;
  localparam integer LAST_POS_I = PAYLOAD_BYTES + REDUND_BYTES - 1;
  localparam integer PAYLOAD_I = PAYLOAD_BYTES;
  localparam integer LAST_BIT_I = `STSO_BITS_PER_BYTE - 1;
  // Cut to register width on purpose; a whole packet must fit the
  // position counter, so payload plus redundancy stays below 257 bytes.
  localparam [PW-1:0] LAST_POS = LAST_POS_I[PW-1:0];
  localparam [PW-1:0] PAYLOAD_CNT = PAYLOAD_I[PW-1:0];
  localparam [2:0] LAST_BIT = LAST_BIT_I[2:0];
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_SHIFT = 2'b10;

  // --------------------------------------------------------------------
  // Reference clock synchroniser and edge detect
  // --------------------------------------------------------------------
  reg ref_s1_q;
  reg ref_s2_q;
  reg ref_s3_q;
  wire fall_tick;

  // Two flops before any logic reads the foreign clock; a third holds
  // the previous level so the edge detector never looks at the first.
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ref_s1_q <= `STSO_RST_LOW;
      ref_s2_q <= `STSO_RST_LOW;
      ref_s3_q <= `STSO_RST_LOW;
    end
    else
    begin
      ref_s1_q <= bit_rate_clk_in;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end

  // Every output bit moves on the falling edge of the bit clock.
  assign fall_tick = ref_s3_q & ~ref_s2_q; // see (R2)

  // --------------------------------------------------------------------
  // Byte buffer
  // --------------------------------------------------------------------
  wire [`STSO_FIFO_W-1:0] fifo_rd_data;
  wire fifo_rd_valid;
  wire fifo_rd_ready;
  wire [7:0] nxt_byte;
  wire nxt_first;
  wire nxt_error;

  stso_fifo #(
    .WIDTH(`STSO_FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .wr_data_in({byte_error_in, byte_first_in, byte_data_in}),
    .wr_valid_in(byte_valid_in),
    .wr_ready_out(byte_ready_out),
    .rd_data_out(fifo_rd_data),
    .rd_valid_out(fifo_rd_valid),
    .rd_ready_in(fifo_rd_ready)
  );

  assign nxt_byte = fifo_rd_data[7:0];
  assign nxt_first = fifo_rd_data[8];
  assign nxt_error = fifo_rd_data[9];

  // --------------------------------------------------------------------
  // Shifter state
  // --------------------------------------------------------------------
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] shift_q;
  reg [7:0] shift_d;
  reg [2:0] bit_q;
  reg [2:0] bit_d;
  reg [PW-1:0] pos_q;
  reg [PW-1:0] pos_d;
  reg err_q;
  reg err_d;
  reg need_byte;

  // A new byte is pulled only on a tick that ends the current byte, so a
  // slow upstream stalls the line instead of corrupting a byte.
  always @*
  begin
    state_d = state_q;
    shift_d = shift_q;
    bit_d = bit_q;
    pos_d = pos_q;
    err_d = err_q;
    need_byte = 1'b0;
    case (state_q)
      ST_SHIFT:
      begin
        if (bit_q != LAST_BIT)
        begin
          shift_d = {shift_q[6:0], 1'b0}; // see (R8)
          bit_d = bit_q + 3'h1; // see (R6)
        end
        else
          need_byte = 1'b1;
      end
      ST_IDLE:
        need_byte = 1'b1;
      default:
      begin
        state_d = ST_IDLE;
        need_byte = 1'b0;
      end
    endcase
    if (need_byte)
    begin
      if (fifo_rd_valid)
      begin
        state_d = ST_SHIFT;
        shift_d = nxt_byte;
        bit_d = 3'h0;
        // The first flag realigns; otherwise wrap after the redundancy.
        if (nxt_first || (pos_q == LAST_POS)) // see (R7)
          pos_d = {PW{1'b0}};
        else
          pos_d = pos_q + {{(PW-1){1'b0}}, 1'b1};
        // Error status is latched once and holds for the whole packet.
        if (nxt_first || (pos_q == LAST_POS))
          err_d = nxt_error; // see (R5)
      end
      else
        state_d = ST_IDLE;
    end
  end

  assign fifo_rd_ready = fall_tick & need_byte;

  // State advances on bit clock falling edges only.
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_q <= ST_IDLE;
      shift_q <= `STSO_RST_BYTE;
      bit_q <= 3'h0;
      pos_q <= LAST_POS;
      err_q <= `STSO_RST_LOW;
    end
    else if (fall_tick)
    begin
      state_q <= state_d;
      shift_q <= shift_d;
      bit_q <= bit_d;
      pos_q <= pos_d;
      err_q <= err_d;
    end
  end

  // --------------------------------------------------------------------
  // Output stage
  // --------------------------------------------------------------------
  wire act_shift;
  wire act_first;
  wire act_valid;
  wire act_error;

  assign act_shift = (state_d == ST_SHIFT);
  // Marker covers all eight bits of byte zero and nothing else.
  assign act_first = act_shift & (pos_d == {PW{1'b0}}); // see (R3)
  // Window closes for the redundancy bytes that trail the payload.
  assign act_valid = act_shift & (pos_d < PAYLOAD_CNT); // see (R4)
  assign act_error = act_shift & err_d; // see (R5)

  // Outputs come straight from flops so no glitch reaches the pins; the
  // bit clock follows the reference three core cycles late, matching data.
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      out_bit_clock_out <= `STSO_RST_LOW;
      serial_stream_out <= `STSO_RST_LOW;
      first_byte_mark_out <= `STSO_RST_LOW;
      packet_valid_window_out <= `STSO_RST_LOW;
      packet_error_flag_out <= `STSO_RST_LOW;
    end
    else
    begin
      out_bit_clock_out <= ref_s2_q ^ inv_clock_in; // see (R1)
      if (fall_tick)
      begin
        serial_stream_out <= act_shift & shift_d[7]; // see (R6) (R8)
        first_byte_mark_out <= act_first ^ inv_first_in; // see (R1)
        packet_valid_window_out <= act_valid ^ inv_valid_in; // see (R1)
        packet_error_flag_out <= act_error ^ inv_error_in; // see (R1)
      end
    end
  end

endmodule // stso_framer

`default_nettype wire

//--- stso_monitor.sv
// Checker for the serial stream framer outputs.
`timescale 1ns/1ps
`default_nettype none
module stso_monitor (
  input wire logic clk_in, // Core clock.
  input wire logic rst_b_in, // Reset, active low.
  input wire logic bit_rate_clk_in, // Bit rate reference.
  input wire logic inv_clock_in, // Clock polarity.
  input wire logic inv_first_in, // Marker polarity.
  input wire logic inv_valid_in, // Window polarity.
  input wire logic inv_error_in, // Error polarity.
  input wire logic out_bit_clock_out, // Bit clock.
  input wire logic serial_stream_out, // Serial data.
  input wire logic first_byte_mark_out, // Marker.
  input wire logic packet_valid_window_out, // Window.
  input wire logic packet_error_flag_out // Error flag.
);
  logic bclk_q;
  logic rose_q;
  logic live_q;
  logic [3:0] mark_cnt_q;
  wire bclk = out_bit_clock_out ^ inv_clock_in;
  wire mark = live_q & (first_byte_mark_out ^ inv_first_in);
  wire vld = live_q & (packet_valid_window_out ^ inv_valid_in);
  wire err = live_q & (packet_error_flag_out ^ inv_error_in);
  // ---------
  // Helpers
  // ---------
  // Strobes read zero in reset whatever the polarity, so they count as
  // live only after a real rise and then fall of the bit clock; the step
  // from the reset level at release is never taken for an edge.
  always @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      bclk_q <= 1'b1;
      rose_q <= 1'b0;
      live_q <= 1'b0;
      mark_cnt_q <= 4'h0;
    end
    else
    begin
      bclk_q <= bclk;
      rose_q <= rose_q | (bclk & ~bclk_q);
      live_q <= live_q | (rose_q & bclk_q & ~bclk);
      mark_cnt_q <= !mark ? 4'h0 : mark_cnt_q + {3'h0, bclk_q & ~bclk};
    end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_data_on_fall:
    assert property ($changed(serial_stream_out) |-> $fell(bclk))
    else $error("Serial data moved off a clock fall.");
  a_strobe_on_fall:
    assert property ($changed({first_byte_mark_out, packet_valid_window_out,
      packet_error_flag_out}) |-> $fell(bclk))
    else $error("A strobe moved off a clock fall.");
  a_clock_track:
    assert property ($fell(bit_rate_clk_in) && $past(rst_b_in) |->
      ##[2:4] $fell(bclk))
    else $error("Bit clock lost its reference.");
  a_mark_eight:
    assert property ($fell(mark) |-> mark_cnt_q == 4'h8)
    else $error("Marker length is not eight bits.");
  a_mark_bound:
    assert property (mark_cnt_q <= 4'h8)
    else $error("Marker stands too long.");
  a_mark_in_window:
    assert property ($rose(mark) |-> vld)
    else $error("Marker outside the payload window.");
  a_window_end:
    assert property ($fell(vld) |-> !mark)
    else $error("Window closed on a first byte.");
  a_error_start:
    assert property ($rose(err) |-> $rose(mark))
    else $error("Error flag rose inside a packet.");
  a_error_end:
    assert property ($fell(err) |-> $rose(mark) || !vld)
    else $error("Error flag fell inside the payload.");
endmodule // stso_monitor
bind stso_framer stso_monitor i_mon (.clk_in, .rst_b_in, .bit_rate_clk_in,
  .inv_clock_in, .inv_first_in, .inv_valid_in, .inv_error_in,
  .out_bit_clock_out, .serial_stream_out, .first_byte_mark_out,
  .packet_valid_window_out, .packet_error_flag_out);
`default_nettype wire

//--- stso_rx_model.sv
// Downstream stream receiver model that rebuilds bytes and strobe flags.
`timescale 1ns/1ps
`default_nettype none
module stso_rx_model (
  input wire logic clk_in, // Core clock.
  input wire logic rst_b_in, // Reset, active low.
  input wire logic bclk_in, // Bit clock, active polarity.
  input wire logic data_in, // Serial data.
  input wire logic [2:0] strb_in, // Marker, window, error, active high.
  output logic rx_stb_out, // One cycle per byte.
  output logic [13:0] rx_word_out // Byte, then all and any per strobe.
);
  logic clk_q;
  logic rose_q;
  logic live_q;
  logic run_q;
  logic [2:0] cnt_q;
  logic [7:0] byte_q;
  logic [2:0] all_q;
  logic [2:0] any_q;
  wire [2:0] all_n = (cnt_q == 3'h0) ? strb_in : all_q & strb_in;
  wire [2:0] any_n = (cnt_q == 3'h0) ? strb_in : any_q | strb_in;
  // ---------
  // Sampling
  // ---------
  // Sample on the rising edge, half a bit away from the launch edge.
  // Byte framing starts at the first marker and then free-runs. The
  // reset level of the pins is no marker: a real rise and fall of the
  // bit clock must pass first, else inverted strobes start it early.
  always @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      clk_q <= 1'b1;
      rose_q <= 1'b0;
      live_q <= 1'b0;
      run_q <= 1'b0;
      cnt_q <= 3'h0;
      rx_stb_out <= 1'b0;
    end
    else
    begin
      clk_q <= bclk_in;
      rose_q <= rose_q | (bclk_in & ~clk_q);
      live_q <= live_q | (rose_q & clk_q & ~bclk_in);
      rx_stb_out <= 1'b0;
      if (bclk_in && !clk_q && (run_q || (live_q && strb_in[2])))
      begin
        run_q <= 1'b1;
        cnt_q <= cnt_q + 3'h1;
        byte_q <= {byte_q[6:0], data_in};
        all_q <= all_n;
        any_q <= any_n;
        rx_stb_out <= (cnt_q == 3'h7);
        rx_word_out <= {byte_q[6:0], data_in, all_n[2], any_n[2],
          all_n[1], any_n[1], all_n[0], any_n[0]};
      end
    end
endmodule // stso_rx_model
`default_nettype wire

//--- stso_tb.sv
// Testbench for the serial stream framer.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int PAY = 12;
  localparam int RED = 4;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic ref_clk = 1'b0;
  logic [7:0] data = 8'h00;
  logic first = 1'b0;
  logic err = 1'b0;
  logic vld = 1'b0;
  logic [3:0] inv = 4'h0;
  logic perr;
  logic [13:0] exp_w;
  logic [13:0] exp_q[$];
  integer seed = 32'hd36a;
  integer failures = 0;
  integer num_checks = 0;
  wire ready, obclk, sdata, omark, owin, oerr, rx_stb;
  wire [13:0] rx_word;
  always #2 clk_in = ~clk_in;
  initial
  begin
    #37;
    forever #80 ref_clk = ~ref_clk;
  end
  stso_framer #(.PAYLOAD_BYTES(PAY), .REDUND_BYTES(RED)) i_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .bit_rate_clk_in(ref_clk),
    .byte_data_in(data), .byte_first_in(first), .byte_error_in(err),
    .byte_valid_in(vld), .byte_ready_out(ready), .inv_clock_in(inv[0]),
    .inv_first_in(inv[1]), .inv_valid_in(inv[2]), .inv_error_in(inv[3]),
    .out_bit_clock_out(obclk), .serial_stream_out(sdata),
    .first_byte_mark_out(omark), .packet_valid_window_out(owin),
    .packet_error_flag_out(oerr));
  stso_rx_model i_rx (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .bclk_in(obclk ^ inv[0]), .data_in(sdata),
    .strb_in({omark ^ inv[1], owin ^ inv[2], oerr ^ inv[3]}),
    .rx_stb_out(rx_stb), .rx_word_out(rx_word));
  task automatic end_sim();
    if (failures == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ---------
  // Stimulus
  // ---------
  // Bytes go in back to back so the fifo fills and refuses; the error
  // input is random on later bytes, where it must be ignored. The second
  // run resets after the stream has drained and flips every polarity, so
  // each level of each polarity input is seen.
  initial
  begin
    inv = $random(seed);
    for (int r = 0; r < 2 && failures == 0; r++)
    begin
      rst_b_in = 1'b0;
      if (r == 1)
        inv = ~inv;
      repeat (20) @(negedge clk_in);
      rst_b_in = 1'b1;
      repeat (100) @(negedge clk_in);
      for (int p = 0; p < 3; p++)
        for (int b = 0; b < PAY + RED; b++)
        begin
          perr = p[0];
          data = $random(seed);
          first = (b == 0);
          err = (b == 0) ? perr : $random(seed);
          vld = 1'b1;
          exp_q.push_back({data, {2{b == 0}}, {2{b < PAY}}, {2{perr}}});
          for (int i = 0; i < 400 && ready !== 1'b1; i++) @(negedge clk_in);
          if (ready !== 1'b1)
            failures++;
          @(negedge clk_in);
        end
      vld = 1'b0;
      for (int i = 0; i < 4000 && exp_q.size() > 0; i++) @(negedge clk_in);
      if (exp_q.size() > 0)
        failures++;
    end
    end_sim();
  end
  // Each rebuilt byte is matched against the oldest note, away from the
  // edge that launches the model's strobe.
  always @(negedge clk_in)
    if (rx_stb === 1'b1 && exp_q.size() > 0)
    begin
      exp_w = exp_q.pop_front();
      num_checks++;
      if (rx_word !== exp_w)
      begin
        $display("ERROR rx_word expected %h seen %h", exp_w, rx_word);
        failures++;
      end
    end
endmodule // tb
`default_nettype wire
